// ### include/ppv_pkg.sv
`default_nettype none
package ppv_pkg;
  // Word indices; byte address is four times the index
  localparam logic [5:0] IDX_COMPLIANCE = 6'h00;
  localparam logic [5:0] IDX_ID_RSVD    = 6'h01;
  localparam logic [5:0] IDX_OUI_HI     = 6'h02;
  localparam logic [5:0] IDX_OUI_MID    = 6'h03;
  localparam logic [5:0] IDX_OUI_LO     = 6'h04;
  localparam logic [5:0] IDX_PART_HI    = 6'h05;
  localparam logic [5:0] IDX_PART_MID   = 6'h06;
  localparam logic [5:0] IDX_PART_LO    = 6'h07;
  localparam logic [5:0] IDX_VND_RSVD0  = 6'h00;
  localparam logic [5:0] IDX_SOFT_RESET = 6'h06;
  localparam logic [5:0] IDX_PAGE_SEL   = 6'h08;
  localparam logic [5:0] IDX_PWR_CLASS  = 6'h09;
  localparam logic [5:0] IDX_PWR_DESC   = 6'h0A;
  localparam logic [5:0] IDX_PAGED_LAST = 6'h07;
  // Pages of the window
  localparam logic [2:0] PAGE_ID        = 3'h1;
  localparam logic [2:0] PAGE_VENDOR    = 3'h7;
  localparam logic [2:0] PAGE_SEL_RESET = 3'h0;
  // Fields and fixed values
  localparam logic [7:0] COMPLIANCE_VAL = 8'h02;
  localparam int unsigned SWR_BIT       = 7;
  localparam int unsigned SELF_ID_PWR_LSB = 8;
  // Soft hard reset pulse width
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned SWR_PULSE_NS  = 16;
  localparam int unsigned SWR_PULSE_CYCLES = SWR_PULSE_NS / CLK_PERIOD_NS;
  // Power class watt figures
  localparam logic [5:0] SUPPLY_W_001 = 6'h0F;
  localparam logic [5:0] SUPPLY_W_010 = 6'h1E;
  localparam logic [5:0] SUPPLY_W_011 = 6'h2D;
  localparam logic [3:0] BUS_DRAW_W   = 4'h3;
  localparam logic [3:0] LINK_W_110   = 4'h3;
  localparam logic [3:0] LINK_W_111   = 4'h7;

  typedef enum logic {
    SR_IDLE  = 1'b0,
    SR_PULSE = 1'b1
  } ppv_swr_state_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } ppv_wb_req_s;

  typedef struct packed {
    logic       self_powered;
    logic       bus_powered;
    logic       supplies_bus;
    logic       reserved;
    logic [3:0] draw_w;
    logic [3:0] link_extra_w;
    logic [5:0] supply_w;
  } ppv_pwr_desc_s;

  function automatic ppv_pwr_desc_s ppv_pwr_decode(input logic [2:0] c);
    ppv_pwr_desc_s d;
    d = '0;
    unique case (c)
      3'b000: d = '0;
      3'b001: begin
        d.self_powered = 1'b1;
        d.supplies_bus = 1'b1;
        d.supply_w     = SUPPLY_W_001;
      end
      3'b010: begin
        d.self_powered = 1'b1;
        d.supplies_bus = 1'b1;
        d.supply_w     = SUPPLY_W_010;
      end
      3'b011: begin
        d.self_powered = 1'b1;
        d.supplies_bus = 1'b1;
        d.supply_w     = SUPPLY_W_011;
      end
      3'b100: begin
        d.bus_powered  = 1'b1;
        d.supplies_bus = 1'b1;
        d.draw_w       = BUS_DRAW_W;
      end
      3'b101: d.reserved = 1'b1;
      3'b110: begin
        d.bus_powered  = 1'b1;
        d.draw_w       = BUS_DRAW_W;
        d.link_extra_w = LINK_W_110;
      end
      3'b111: begin
        d.bus_powered  = 1'b1;
        d.draw_w       = BUS_DRAW_W;
        d.link_extra_w = LINK_W_111;
      end
    endcase
    return d;
  endfunction
endpackage
`default_nettype wire

// ### rtl/ppv_pages.sv
// Overview of operation
// - First identification location reads compliance 02h
// - Organisation identifier, three bytes, MSB first
// - Product code, three bytes, MSB first
// - Vendor page mapped only when selector is 7
// - Writing one to reset bit hard-resets PHY
// - Reset bit always reads as zero
// - Power class goes into self-ID bits 8-10
// - Straps latched on hard reset, writes override
// - Codes 000 to 011: none, self-powered 15/30/45W
// - Code 100 bus-powered 3W may supply; 101 reserved
// - Codes 110/111 need extra 3W/7W for link
`timescale 1ns/1ps
`default_nettype none
module ppv_pages #(
  parameter logic [23:0] MAKER_OUI = 24'h12_34_56, // Arbitrary value
  parameter logic [23:0] PART_CODE = 24'h00_00_01  // Arbitrary value
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire ppv_pkg::ppv_wb_req_s   wb_req_i,
  output var  logic [31:0]            wb_dat_o,
  output var  logic                   wb_ack_o,
  input  wire logic [2:0]             power_class_straps_i,
  input  wire logic [31:0]            self_id_i,
  input  wire logic                   self_id_valid_i,
  output var  logic [31:0]            self_id_o,
  output var  logic                   self_id_valid_o,
  output var  logic                   phy_hard_reset_o,
  output var  logic [2:0]             pwr_class_o,
  output var  ppv_pkg::ppv_pwr_desc_s pwr_desc_o
);
  import ppv_pkg::*;

  logic           ack_reg;
  logic [31:0]    dat_reg;
  logic [2:0]     page_reg;
  logic [2:0]     pwr_class_reg;
  ppv_pwr_desc_s  pwr_desc_reg;
  logic [31:0]    self_id_reg;
  logic           self_id_valid_reg;
  logic           hard_reset_reg;
  ppv_swr_state_e swr_state_reg;
  ppv_swr_state_e swr_state_next;
  logic [7:0]     swr_cnt_reg;
  logic           req;
  logic           rd_take;
  logic           wr_take;
  logic           hard_rst;
  logic           swr_write;
  logic [5:0]     idx;
  logic [31:0]    rd_data;

  assign req      = wb_req_i.cyc & wb_req_i.stb;
  assign idx      = wb_req_i.adr[7:2];
  assign rd_take  = req & ~wb_req_i.we & ~ack_reg;
  // Write lands on the edge where the master sees ack
  assign wr_take  = req & wb_req_i.we & ack_reg & wb_req_i.sel[0];
  assign hard_rst = rst_i | hard_reset_reg;
  assign swr_write = wr_take & (page_reg == PAGE_VENDOR)
                   & (idx == IDX_SOFT_RESET)
                   & wb_req_i.dat[SWR_BIT];

  assign wb_dat_o         = dat_reg;
  assign wb_ack_o         = ack_reg;
  assign phy_hard_reset_o = hard_reset_reg;
  assign pwr_class_o      = pwr_class_reg;
  assign pwr_desc_o       = pwr_desc_reg;
  assign self_id_o        = self_id_reg;
  assign self_id_valid_o  = self_id_valid_reg;

  // Bus acknowledge, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // Read multiplexer over the paged window and own registers
  always_comb begin
    rd_data = 32'h0000_0000;
    if (idx <= IDX_PAGED_LAST) begin
      if (page_reg == PAGE_ID) begin
        unique case (idx)
          IDX_COMPLIANCE: rd_data[7:0] = COMPLIANCE_VAL;
          IDX_OUI_HI:     rd_data[7:0] = MAKER_OUI[23:16];
          IDX_OUI_MID:    rd_data[7:0] = MAKER_OUI[15:8];
          IDX_OUI_LO:     rd_data[7:0] = MAKER_OUI[7:0];
          IDX_PART_HI:    rd_data[7:0] = PART_CODE[23:16];
          IDX_PART_MID:   rd_data[7:0] = PART_CODE[15:8];
          IDX_PART_LO:    rd_data[7:0] = PART_CODE[7:0];
          default:        rd_data = 32'h0000_0000;
        endcase
      end else begin
        // Any page but the ID page reads zero, vendor reset bit and test bytes included
        rd_data = 32'h0000_0000;
      end
    end else if (idx == IDX_PAGE_SEL) begin
      rd_data[2:0] = page_reg;
    end else if (idx == IDX_PWR_CLASS) begin
      rd_data[2:0] = pwr_class_reg;
    end else if (idx == IDX_PWR_DESC) begin
      rd_data[17:0] = pwr_desc_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      dat_reg <= rd_data;
    end else begin
      dat_reg <= 32'h0000_0000;
    end
  end

  // Page selector
  always_ff @(posedge clk_i) begin
    if (hard_rst) begin
      page_reg <= PAGE_SEL_RESET;
    end else if (wr_take && idx == IDX_PAGE_SEL) begin
      page_reg <= wb_req_i.dat[2:0];
    end
  end

  // Power class: straps on hard reset, software after
  always_ff @(posedge clk_i) begin
    if (hard_rst) begin
      pwr_class_reg <= power_class_straps_i;
    end else if (wr_take && idx == IDX_PWR_CLASS) begin
      pwr_class_reg <= wb_req_i.dat[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_desc_reg <= ppv_pwr_decode(power_class_straps_i);
    end else begin
      pwr_desc_reg <= ppv_pwr_decode(pwr_class_reg);
    end
  end

  // Self-ID power field insertion
  always_ff @(posedge clk_i) begin
    if (hard_rst) begin
      self_id_valid_reg <= 1'b0;
      self_id_reg       <= 32'h0000_0000;
    end else begin
      self_id_valid_reg <= self_id_valid_i;
      self_id_reg       <= self_id_i;
      if (self_id_valid_i) begin
        self_id_reg[SELF_ID_PWR_LSB +: 3] <= pwr_class_reg;
      end
    end
  end

  // Soft hard reset sequencer
  always_comb begin
    swr_state_next = swr_state_reg;
    unique case (swr_state_reg)
      SR_IDLE:  if (swr_write) swr_state_next = SR_PULSE;
      SR_PULSE: if (swr_cnt_reg == 8'h00) swr_state_next = SR_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      swr_state_reg <= SR_IDLE;
      swr_cnt_reg   <= 8'h00;
    end else begin
      swr_state_reg <= swr_state_next;
      if (swr_state_reg == SR_IDLE) begin
        swr_cnt_reg <= 8'(SWR_PULSE_CYCLES - 1);
      end else if (swr_cnt_reg != 8'h00) begin
        swr_cnt_reg <= swr_cnt_reg - 8'h01;
      end
    end
  end

  // Hard reset output: external reset or soft pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hard_reset_reg <= 1'b1;
    end else begin
      hard_reset_reg <= (swr_state_next == SR_PULSE);
    end
  end

  a_compliance_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_take && idx == IDX_COMPLIANCE && page_reg == PAGE_ID)
      |=> (wb_dat_o == {24'h00_0000, COMPLIANCE_VAL}) && wb_ack_o)
    else $error("compliance level read wrong");

  a_oui_bytes_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_take && idx == IDX_OUI_HI && page_reg == PAGE_ID)
      |=> wb_dat_o[7:0] == MAKER_OUI[23:16])
    else $error("organisation identifier high byte wrong");

  a_part_code_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_take && idx == IDX_PART_LO && page_reg == PAGE_ID)
      |=> wb_dat_o[7:0] == PART_CODE[7:0])
    else $error("product code low byte wrong");

  a_page_gate_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_take && idx == IDX_SOFT_RESET && page_reg != PAGE_VENDOR
      && swr_state_reg == SR_IDLE)
      |=> !phy_hard_reset_o)
    else $error("vendor page reached without selector 7");

  a_swr_pulse_len: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (swr_write && swr_state_reg == SR_IDLE)
      |=> phy_hard_reset_o [*4] ##1 !phy_hard_reset_o)
    else $error("soft hard reset pulse width wrong");

  a_swr_reads_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_take && idx == IDX_SOFT_RESET && page_reg == PAGE_VENDOR)
      |=> wb_dat_o == 32'h0000_0000)
    else $error("reset bit read back nonzero");

  a_selfid_power: assert property (
    @(posedge clk_i) disable iff (hard_rst)
    self_id_valid_i |=> self_id_valid_o
      && self_id_o[10:8] == $past(pwr_class_reg)
      && self_id_o[31:11] == $past(self_id_i[31:11])
      && self_id_o[7:0] == $past(self_id_i[7:0]))
    else $error("self-ID power field wrong");

  a_strap_latch: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $fell(phy_hard_reset_o) |-> pwr_class_reg == $past(power_class_straps_i))
    else $error("straps not latched at hard reset");

  a_pwr_write: assert property (
    @(posedge clk_i) disable iff (hard_rst)
    (wr_take && idx == IDX_PWR_CLASS) |=> ##1
      pwr_class_o == $past(wb_req_i.dat[2:0], 2)
      && pwr_desc_o == ppv_pwr_decode($past(wb_req_i.dat[2:0], 2)))
    else $error("power class write not taken");

  a_class_self: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $past(pwr_class_reg) == 3'b011 |-> pwr_desc_o.self_powered
      && pwr_desc_o.supply_w == 6'h2D && !pwr_desc_o.bus_powered)
    else $error("class 011 decode wrong");

  a_class_bus_gen: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $past(pwr_class_reg) == 3'b100 |-> pwr_desc_o.bus_powered
      && pwr_desc_o.supplies_bus && pwr_desc_o.draw_w == 4'h3
      && pwr_desc_o.link_extra_w == 4'h0)
    else $error("class 100 decode wrong");

  a_class_bus_link: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $past(pwr_class_reg) == 3'b111 |-> pwr_desc_o.bus_powered
      && pwr_desc_o.draw_w == 4'h3 && pwr_desc_o.link_extra_w == 4'h7)
    else $error("class 111 decode wrong");

  a_test_reads_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_take && idx <= IDX_PAGED_LAST && idx != IDX_VND_RSVD0
      && page_reg == PAGE_VENDOR) |=> wb_dat_o == 32'h0000_0000)
    else $error("test location read nonzero");

  a_ack_single: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for two cycles");

  a_oui_mid_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_take && idx == IDX_OUI_MID && page_reg == PAGE_ID)
      |=> wb_dat_o == {24'h00_0000, MAKER_OUI[15:8]})
    else $error("organisation identifier middle byte wrong");

  a_oui_lo_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_take && idx == IDX_OUI_LO && page_reg == PAGE_ID)
      |=> wb_dat_o == {24'h00_0000, MAKER_OUI[7:0]})
    else $error("organisation identifier low byte wrong");

  a_part_hi_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_take && idx == IDX_PART_HI && page_reg == PAGE_ID)
      |=> wb_dat_o == {24'h00_0000, PART_CODE[23:16]})
    else $error("product code high byte wrong");

  a_part_mid_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_take && idx == IDX_PART_MID && page_reg == PAGE_ID)
      |=> wb_dat_o == {24'h00_0000, PART_CODE[15:8]})
    else $error("product code middle byte wrong");

  a_id_rsvd_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_take && idx == IDX_ID_RSVD && page_reg == PAGE_ID)
      |=> wb_dat_o == 32'h0000_0000)
    else $error("reserved identification byte read nonzero");

  a_other_page_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_take && idx <= IDX_PAGED_LAST && page_reg != PAGE_ID
      && page_reg != PAGE_VENDOR) |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped page read nonzero");

  a_ack_timing: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o) |=> wb_ack_o)
    else $error("ack not given one cycle after request");

  a_dat_idle_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data nonzero outside ack");

  a_page_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_take && idx == IDX_PAGE_SEL && !phy_hard_reset_o)
      |=> page_reg == $past(wb_req_i.dat[2:0]))
    else $error("page selector write not taken");

  a_page_hard_reset: assert property (
    @(posedge clk_i) disable iff (rst_i)
    phy_hard_reset_o |=> page_reg == PAGE_SEL_RESET)
    else $error("page selector kept through hard reset");

  a_strap_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    phy_hard_reset_o |=> pwr_class_o == $past(power_class_straps_i))
    else $error("straps not loaded during hard reset");

  a_selfid_held: assert property (
    @(posedge clk_i) disable iff (rst_i)
    phy_hard_reset_o |=> !self_id_valid_o
      && self_id_o == 32'h0000_0000)
    else $error("self-ID output active during hard reset");

  a_selfid_pass: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!self_id_valid_i && !phy_hard_reset_o)
      |=> !self_id_valid_o && self_id_o == $past(self_id_i))
    else $error("idle self-ID word altered");

  a_class_none: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $past(pwr_class_reg) == 3'h0 |-> pwr_desc_o == '0)
    else $error("class 000 decode wrong");

  a_class_low_supply: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $past(pwr_class_reg) == 3'h1 |-> pwr_desc_o.self_powered
      && pwr_desc_o.supplies_bus && pwr_desc_o.supply_w == 6'h0F)
    else $error("class 001 decode wrong");

  a_class_mid_supply: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $past(pwr_class_reg) == 3'h2 |-> pwr_desc_o.self_powered
      && pwr_desc_o.supply_w == 6'h1E && !pwr_desc_o.bus_powered)
    else $error("class 010 decode wrong");

  a_class_reserved: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $past(pwr_class_reg) == 3'h5 |-> pwr_desc_o.reserved
      && !pwr_desc_o.self_powered && !pwr_desc_o.bus_powered)
    else $error("class 101 decode wrong");

  a_class_bus_small: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $past(pwr_class_reg) == 3'h6 |-> pwr_desc_o.bus_powered
      && !pwr_desc_o.supplies_bus && pwr_desc_o.draw_w == 4'h3
      && pwr_desc_o.link_extra_w == 4'h3)
    else $error("class 110 decode wrong");
endmodule
`default_nettype wire

// ### bench/ppv_llc_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppv_llc_model (
  input  wire logic                 clk_i,
  output var  ppv_pkg::ppv_wb_req_s req_o,
  input  wire logic [31:0]          dat_i,
  input  wire logic                 ack_i
);
  import ppv_pkg::*;
  int n_timeout = 0;
  initial req_o = '0;
  // One classic cycle, held until ack is sampled high
  task automatic xfer(input logic we, input logic [5:0] idx,
                      input logic [7:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'h0},
               sel: 4'hF, dat: {24'h0, wd}};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 50);
    if (n >= 50) n_timeout++;
    rd = dat_i;
    req_o.cyc <= 1'b0;
    req_o.stb <= 1'b0;
    req_o.adr <= ~req_o.adr;
    req_o.dat <= ~req_o.dat;
  endtask
  // Selector names the page before its window is used
  task automatic page(input logic [2:0] p);
    logic [31:0] rd;
    xfer(1'b1, IDX_PAGE_SEL, {5'h0, p}, rd);
  endtask
endmodule
`default_nettype wire

// ### bench/phy_id_and_vendor_pages_test.sv
`timescale 1ns/1ps
`default_nettype none
module phy_id_and_vendor_pages_test;
  import ppv_pkg::*;
  localparam logic [23:0] OUI  = 24'h65_43_21; // Arbitrary value
  localparam logic [23:0] PART = 24'h00_0A_0B; // Arbitrary value
  logic          clk_i = 1'b0;
  logic          rst_i = 1'b1;
  ppv_wb_req_s   req;
  logic [31:0]   rdat;
  logic          ack;
  logic [2:0]    straps = 3'h6;
  logic [31:0]   sid = 32'h0;
  logic          sid_v = 1'b0;
  logic [31:0]   sid_o;
  logic          sid_v_o;
  logic          hrst;
  logic [2:0]    pcls;
  ppv_pwr_desc_s desc;
  logic [31:0]   rd;
  int            fail_count = 0;
  int            n_compared = 0;

  always #2 clk_i = ~clk_i;

  ppv_pages #(.MAKER_OUI(OUI), .PART_CODE(PART)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(rdat),
    .wb_ack_o(ack), .power_class_straps_i(straps), .self_id_i(sid),
    .self_id_valid_i(sid_v), .self_id_o(sid_o),
    .self_id_valid_o(sid_v_o), .phy_hard_reset_o(hrst),
    .pwr_class_o(pcls), .pwr_desc_o(desc));
  ppv_llc_model i_llc (.clk_i(clk_i), .req_o(req), .dat_i(rdat),
                       .ack_i(ack));

  task automatic stop_test();
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
    i_llc.xfer(1'b0, idx, 8'h00, rd);
    chk(rd, {24'h0, exp}, "read");
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    i_llc.xfer(1'b1, idx, d, rd);
  endtask

  function automatic ppv_pwr_desc_s exp_desc(input logic [2:0] c);
    ppv_pwr_desc_s d;
    d = '0;
    d.self_powered = c inside {3'h1, 3'h2, 3'h3};
    d.supplies_bus = c inside {3'h1, 3'h2, 3'h3, 3'h4};
    d.bus_powered  = c inside {3'h4, 3'h6, 3'h7};
    d.reserved     = (c == 3'h5);
    d.draw_w       = d.bus_powered ? BUS_DRAW_W : 4'h0;
    d.link_extra_w = c == 3'h6 ? LINK_W_110 : c == 3'h7 ? LINK_W_111 : 4'h0;
    d.supply_w     = c == 3'h1 ? SUPPLY_W_001 : c == 3'h2 ? SUPPLY_W_010
                   : c == 3'h3 ? SUPPLY_W_011 : 6'h00;
    return d;
  endfunction

  task automatic t_id_page();
    rd_chk(IDX_PAGE_SEL, {5'h0, PAGE_SEL_RESET});
    rd_chk(IDX_PWR_CLASS, 8'h06);
    i_llc.page(PAGE_ID);
    wr(IDX_COMPLIANCE, 8'hFF);
    wr(IDX_ID_RSVD, 8'hFF);
    wr(IDX_OUI_HI, 8'h00);
    rd_chk(IDX_COMPLIANCE, 8'h02);
    rd_chk(IDX_ID_RSVD, 8'h00);
    rd_chk(IDX_OUI_HI, OUI[23:16]);
    rd_chk(IDX_OUI_MID, OUI[15:8]);
    rd_chk(IDX_OUI_LO, OUI[7:0]);
    rd_chk(IDX_PART_HI, PART[23:16]);
    rd_chk(IDX_PART_MID, PART[15:8]);
    rd_chk(IDX_PART_LO, PART[7:0]);
    wr(IDX_SOFT_RESET, 8'h80);
    rd_chk(IDX_PAGE_SEL, {5'h0, PAGE_ID});
    i_llc.page(3'h6);
    rd_chk(IDX_COMPLIANCE, 8'h00);
  endtask

  task automatic t_power();
    for (int c = 0; c < 8; c++) begin
      wr(IDX_PWR_CLASS, 8'(c));
      @(posedge clk_i);
      sid <= 32'hA5A5_5A5A;
      sid_v <= 1'b1;
      @(posedge clk_i);
      sid_v <= 1'b0;
      #1 chk(sid_o, {16'hA5A5, 5'h0B, 3'(c), 8'h5A}, "sid");
      chk(32'(sid_v_o), 32'h1, "sid valid");
      @(posedge clk_i);
      #1 chk(32'(pcls), 32'(c), "class");
      chk(32'(desc), 32'(exp_desc(3'(c))), "desc");
      rd_chk(IDX_PWR_CLASS, 8'(c));
      i_llc.xfer(1'b0, IDX_PWR_DESC, 8'h00, rd);
      chk(rd, 32'(exp_desc(3'(c))), "desc reg");
    end
  endtask

  task automatic t_soft_reset();
    int n;
    int k;
    n = 0;
    k = 0;
    i_llc.page(PAGE_VENDOR);
    wr(IDX_VND_RSVD0, 8'hFF);
    wr(6'h01, 8'hFF);
    rd_chk(IDX_VND_RSVD0, 8'h00);
    rd_chk(6'h01, 8'h00);
    straps <= 3'h3;
    wr(IDX_SOFT_RESET, 8'h80);
    sid_v <= 1'b1;
    repeat (12) @(posedge clk_i) begin
      if (hrst === 1'b1) n++;
      if (hrst === 1'b1 && sid_v_o !== 1'b0) k++;
    end
    sid_v <= 1'b0;
    chk(n, SWR_PULSE_CYCLES, "pulse");
    chk(k, 32'h0, "sid valid in reset");
    rd_chk(IDX_PAGE_SEL, 8'h00);
    rd_chk(IDX_PWR_CLASS, 8'h03);
    i_llc.page(PAGE_VENDOR);
    rd_chk(IDX_SOFT_RESET, 8'h00);
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_id_page();
    t_power();
    t_soft_reset();
    chk(i_llc.n_timeout, 32'h0, "bus timeout");
    stop_test();
  end

  initial begin
    #20000;
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
